// file: inc/vcie_pkg.sv
// Package with encodings, field positions and widths of the virtual EOI control block
package vcie_pkg;
  // System register encoding op0,op1,CRn,CRm,op2 packed into 16 bits
  localparam logic [15:0] ENC_CTRL = {2'b11, 3'b000, 4'b1100, 4'b1100, 3'b100};
  localparam logic [15:0] ENC_DEACT = {2'b11, 3'b000, 4'b1100, 4'b1011, 3'b001};
  localparam logic [15:0] ENC_EOI0 = {2'b11, 3'b000, 4'b1100, 4'b1000, 3'b001};
  localparam logic [15:0] ENC_BPR0 = {2'b11, 3'b000, 4'b1100, 4'b1000, 3'b011};
  localparam logic [15:0] ENC_BPR1 = {2'b11, 3'b000, 4'b1100, 4'b1100, 3'b011};
  localparam int ENC_W = 16;
  localparam int DATA_W = 32;
  localparam int ID_W = 24;
  localparam int ID16_W = 16;
  localparam int BP_W = 3;
  localparam int IDW_LSB = 11;
  localparam int PRIW_LSB = 8;
  localparam int SPLIT_BIT = 1;
  localparam int SHARED_BIT = 0;
  localparam logic [2:0] IDW_16 = 3'h0;
  localparam logic [2:0] IDW_24 = 3'h1;
  localparam logic [2:0] BP_MAX = 3'h7;
  localparam logic [2:0] BP_ONE = 3'h1;
  localparam int MIN_PRI_BITS = 5;
  localparam int MAX_PRI_BITS = 8;
  // Access outcome
  typedef enum logic [2:0] {
    VCIE_OK_VIRT = 3'b000,
    VCIE_OK_PHYS = 3'b001,
    VCIE_TRAP_EL2 = 3'b011,
    VCIE_TRAP_EL1 = 3'b010
  } vcie_route_t;
endpackage

// file: rtl/vcie_eoi_ctrl.sv
// Virtual CPU interface control, deactivate and group 0 end-of-interrupt logic
`timescale 1ns/1ps
`default_nettype none
module vcie_eoi_ctrl #(
  parameter int PRI_BITS = 5,
  parameter int ID_BITS = 16,
  parameter logic [2:0] BPR0_MIN = 3'h2
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic acc_valid_i,
  input wire logic acc_write_i,
  input wire logic [vcie_pkg::ENC_W-1:0] acc_enc_i,
  input wire logic [vcie_pkg::DATA_W-1:0] acc_wdata_i,
  input wire logic el1_i,
  input wire logic nonsecure_i,
  input wire logic sysreg_enable_i,
  input wire logic trap_common_regs_i,
  input wire logic trap_deactivate_i,
  input wire logic trap_group0_all_i,
  input wire logic fiq_route_override_i,
  input wire logic irq_route_override_i,
  input wire logic [vcie_pkg::BP_W-1:0] group0_binary_point_i,
  output logic acc_done_o,
  output logic [vcie_pkg::DATA_W-1:0] acc_rdata_o,
  output logic trap_el1_o,
  output logic trap_el2_o,
  output logic phys_access_o,
  output logic prio_drop_o,
  output logic deactivate_o,
  output logic [vcie_pkg::ID_W-1:0] interrupt_identifier_o,
  output logic system_error_interrupt_o,
  output logic split_eoi_select_o,
  output logic shared_binary_point_o,
  output logic [vcie_pkg::BP_W-1:0] group1_binary_point_o,
  output logic [vcie_pkg::BP_W-1:0] group1_preempt_point_o
);
  import vcie_pkg::*;

  localparam logic [BP_W-1:0] BPR1_MIN = BPR0_MIN + BP_ONE;
  localparam logic [2:0] PRIW_CODE = 3'(PRI_BITS - 1);
  localparam logic [2:0] IDW_CODE = (ID_BITS == ID_W) ? IDW_24 : IDW_16;

  localparam int CODE_W = 3;

  if (PRI_BITS < MIN_PRI_BITS || PRI_BITS > MAX_PRI_BITS) begin : g_bad_pri
    $error("Priority width parameter outside the supported range");
  end

  typedef enum logic [2:0] {
    VCIE_REG_NONE = 3'h0,
    VCIE_REG_CTRL = 3'h1,
    VCIE_REG_DEACT = 3'h3,
    VCIE_REG_EOI0 = 3'h2,
    VCIE_REG_BPR1 = 3'h6
  } vcie_reg_t;

  // Register decode, shared by the routing and by the response logic
  function automatic vcie_reg_t kind_of(input logic [ENC_W-1:0] enc);
    case (enc)
      ENC_CTRL: kind_of = VCIE_REG_CTRL;
      ENC_DEACT: kind_of = VCIE_REG_DEACT;
      ENC_EOI0: kind_of = VCIE_REG_EOI0;
      ENC_BPR1: kind_of = VCIE_REG_BPR1;
      default: kind_of = VCIE_REG_NONE;
    endcase
  endfunction

  // Control read image: fixed codes, reserved bits stay zero
  function automatic logic [DATA_W-1:0] ctrl_image(input logic split, input logic shared);
    logic [DATA_W-1:0] img;
    img = '0;
    img[IDW_LSB+:CODE_W] = IDW_CODE;
    img[PRIW_LSB+:CODE_W] = PRIW_CODE;
    img[SPLIT_BIT] = split;
    img[SHARED_BIT] = shared;
    ctrl_image = img;
  endfunction

  function automatic vcie_route_t route_of(input logic [ENC_W-1:0] enc, input logic ns, input logic el1,
                                           input logic sysreg_enable, input logic tc, input logic trap_deactivate,
                                           input logic trap_group0_all, input logic fiq_route_override, input logic irq_route_override,
                                           input logic wr);
    logic virt_sel;
    logic el2_trap;
    virt_sel = 1'b0;
    el2_trap = 1'b0;
    case (kind_of(enc))
      VCIE_REG_CTRL: begin
        virt_sel = fiq_route_override | irq_route_override;
        el2_trap = tc;
      end
      VCIE_REG_DEACT: begin
        virt_sel = fiq_route_override | irq_route_override;
        el2_trap = wr & (tc | trap_deactivate);
      end
      VCIE_REG_EOI0: begin
        virt_sel = fiq_route_override;
        el2_trap = wr & trap_group0_all;
      end
      // Group 1 binary point follows the IRQ override; its group 1 trap is not an input here
      VCIE_REG_BPR1: begin
        virt_sel = irq_route_override;
        el2_trap = 1'b0;
      end
      default: begin
        virt_sel = 1'b0;
        el2_trap = 1'b0;
      end
    endcase
    if (!(ns && el1)) begin
      route_of = VCIE_OK_PHYS;
    end else if (!sysreg_enable) begin
      route_of = VCIE_TRAP_EL1;
    end else if (el2_trap) begin
      route_of = VCIE_TRAP_EL2;
    end else if (virt_sel) begin
      route_of = VCIE_OK_VIRT;
    end else begin
      route_of = VCIE_OK_PHYS;
    end
  endfunction

  vcie_reg_t kind;
  logic hit_virt;
  logic split_reg, split_next;
  logic shared_reg, shared_next;
  logic [BP_W-1:0] bpr1_reg, bpr1_next;
  logic done_reg, done_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic t1_reg, t1_next, t2_reg, t2_next, phys_reg, phys_next;
  logic drop_reg, drop_next, deact_reg, deact_next, sei_reg, sei_next;
  logic [ID_W-1:0] id_reg, id_next;
  logic [ID_W-1:0] wid;
  logic [BP_W-1:0] bpr0_plus;
  vcie_route_t route;

  // Decode shared by all state groups
  always_comb begin
    route = route_of(acc_enc_i, nonsecure_i, el1_i, sysreg_enable_i, trap_common_regs_i,
                     trap_deactivate_i, trap_group0_all_i, fiq_route_override_i,
                     irq_route_override_i, acc_write_i);
    kind = kind_of(acc_enc_i);
    hit_virt = acc_valid_i && route == VCIE_OK_VIRT;
    // upper id bits reserved when 16-bit
    wid = (ID_BITS == ID_W) ? acc_wdata_i[ID_W-1:0] : {8'h00, acc_wdata_i[ID16_W-1:0]};
    bpr0_plus = (group0_binary_point_i == BP_MAX) ? BP_MAX : group0_binary_point_i + BP_ONE;
  end

  // Only the two mode bits are writable; the codes are rebuilt on every read
  always_comb begin
    split_next = split_reg;
    shared_next = shared_reg;
    if (hit_virt && acc_write_i && kind == VCIE_REG_CTRL) begin
      split_next = acc_wdata_i[SPLIT_BIT];
      shared_next = acc_wdata_i[SHARED_BIT];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    split_reg <= split_next;
    shared_reg <= shared_next;
  end

  // Group 1 binary point restarts at its floor, never below it
  always_comb begin
    bpr1_next = bpr1_reg;
    if (srst_i) begin
      bpr1_next = BPR1_MIN;
    end else if (hit_virt && acc_write_i && kind == VCIE_REG_BPR1) begin
      if (!shared_reg) begin
        bpr1_next = (acc_wdata_i[BP_W-1:0] < BPR1_MIN) ? BPR1_MIN : acc_wdata_i[BP_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    bpr1_reg <= bpr1_next;
  end

  // Result pulses and read data stand for one cycle only
  always_comb begin
    done_next = acc_valid_i;
    rdata_next = '0;
    t1_next = acc_valid_i && route == VCIE_TRAP_EL1;
    t2_next = acc_valid_i && route == VCIE_TRAP_EL2;
    phys_next = acc_valid_i && route == VCIE_OK_PHYS;
    drop_next = 1'b0;
    deact_next = 1'b0;
    sei_next = 1'b0;
    id_next = id_reg;
    if (hit_virt) begin
      case (kind)
        VCIE_REG_CTRL: begin
          if (!acc_write_i) begin
            rdata_next = ctrl_image(split_reg, shared_reg);
          end
        end
        VCIE_REG_DEACT: begin
          if (acc_write_i) begin
            if (split_reg) begin
              deact_next = 1'b1;
              id_next = wid;
            end else begin
              sei_next = 1'b1;
            end
          end
        end
        VCIE_REG_EOI0: begin
          if (acc_write_i) begin
            id_next = wid;
            drop_next = 1'b1;
            deact_next = ~split_reg;
          end
        end
        VCIE_REG_BPR1: begin
          if (!acc_write_i) begin
            rdata_next[BP_W-1:0] = shared_reg ? bpr0_plus : bpr1_reg;
          end
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
    if (srst_i) begin
      done_next = 1'b0;
      rdata_next = '0;
      t1_next = 1'b0;
      t2_next = 1'b0;
      phys_next = 1'b0;
      drop_next = 1'b0;
      deact_next = 1'b0;
      sei_next = 1'b0;
      id_next = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    done_reg <= done_next;
    rdata_reg <= rdata_next;
    t1_reg <= t1_next;
    t2_reg <= t2_next;
    phys_reg <= phys_next;
    drop_reg <= drop_next;
    deact_reg <= deact_next;
    sei_reg <= sei_next;
    id_reg <= id_next;
  end

  assign acc_done_o = done_reg;
  assign acc_rdata_o = rdata_reg;
  assign trap_el1_o = t1_reg;
  assign trap_el2_o = t2_reg;
  assign phys_access_o = phys_reg;
  assign prio_drop_o = drop_reg;
  assign deactivate_o = deact_reg;
  assign interrupt_identifier_o = id_reg;
  assign system_error_interrupt_o = sei_reg;
  assign split_eoi_select_o = split_reg;
  assign shared_binary_point_o = shared_reg;
  assign group1_binary_point_o = bpr1_reg;
  assign group1_preempt_point_o = shared_reg ? bpr0_plus : bpr1_reg;
endmodule
`default_nettype wire

// file: test/vcie_eoi_chk.sv
// Assertion checker for the virtual EOI control block
`timescale 1ns/1ps
`default_nettype none
module vcie_eoi_chk import vcie_pkg::*; #(
  parameter int PRI_BITS = 5,
  parameter int ID_BITS = 16,
  parameter logic [2:0] BPR0_MIN = 3'h2
) (
  input wire logic clk_sys_i, srst_i, acc_valid_i, acc_write_i, el1_i, nonsecure_i,
  input wire logic sysreg_enable_i, trap_common_regs_i, trap_deactivate_i, trap_group0_all_i,
  input wire logic fiq_route_override_i, irq_route_override_i,
  input wire logic [ENC_W-1:0] acc_enc_i,
  input wire logic acc_done_o, trap_el1_o, trap_el2_o, phys_access_o, prio_drop_o,
  input wire logic deactivate_o, system_error_interrupt_o, split_eoi_select_o,
  input wire logic [DATA_W-1:0] acc_rdata_o,
  input wire logic [BP_W-1:0] group1_binary_point_o
);
  logic nse, ok, ovr, wr, rd_ctrl;
  assign nse = acc_valid_i & nonsecure_i & el1_i;
  assign ok = nse & sysreg_enable_i;
  assign wr = ok & acc_write_i;
  assign ovr = fiq_route_override_i | irq_route_override_i;
  assign rd_ctrl = ok & ~acc_write_i & (acc_enc_i == ENC_CTRL) & ~trap_common_regs_i & ovr;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  a_sre_trap: assert property (nse && !sysreg_enable_i |=> trap_el1_o && !trap_el2_o && !phys_access_o)
    else $error("enable low did not trap to EL1");
  a_ctrl_el2: assert property (ok && trap_common_regs_i && acc_enc_i == ENC_CTRL |=> trap_el2_o)
    else $error("control access missed EL2 trap");
  a_ctrl_phys: assert property (ok && !trap_common_regs_i && !ovr && acc_enc_i == ENC_CTRL |=> phys_access_o)
    else $error("control access not physical");
  a_deact_el2: assert property (wr && (trap_common_regs_i || trap_deactivate_i) && acc_enc_i == ENC_DEACT
    |=> trap_el2_o)
    else $error("deactivate missed EL2 trap");
  a_deact_phys: assert property (wr && !trap_common_regs_i && !trap_deactivate_i && !ovr
    && acc_enc_i == ENC_DEACT |=> phys_access_o)
    else $error("deactivate not physical");
  a_eoi_el2: assert property (wr && trap_group0_all_i && acc_enc_i == ENC_EOI0 |=> trap_el2_o)
    else $error("EOI missed EL2 trap");
  a_eoi_route: assert property (wr && !trap_group0_all_i && acc_enc_i == ENC_EOI0
    |=> phys_access_o == !$past(fiq_route_override_i))
    else $error("EOI routed wrongly");
  a_eoi_drop: assert property (wr && !trap_group0_all_i && fiq_route_override_i && acc_enc_i == ENC_EOI0
    |=> prio_drop_o && deactivate_o == !$past(split_eoi_select_o))
    else $error("EOI drop or deactivate wrong");
  a_deact_split: assert property (wr && !trap_common_regs_i && !trap_deactivate_i && ovr
    && acc_enc_i == ENC_DEACT |=> deactivate_o == $past(split_eoi_select_o))
    else $error("deactivate ignores split mode");
  a_ctrl_fields: assert property (rd_ctrl |=> acc_done_o
    && acc_rdata_o[13:2] == {(ID_BITS == 24) ? IDW_24 : IDW_16, 3'(PRI_BITS - 1), 6'h0})
    else $error("control read-only fields wrong");
  a_bpr1_floor: assert property (group1_binary_point_o >= BPR0_MIN + 3'h1)
    else $error("group1 binary point below floor");
  cover property (rd_ctrl);
  cover property (wr && acc_enc_i == ENC_DEACT && split_eoi_select_o);
  cover property (nse && !sysreg_enable_i);
endmodule
`default_nettype wire

// file: test/vcie_eoi_ctrl_bench.sv
// Self-checking testbench for the virtual EOI control block
`timescale 1ns/1ps
`default_nettype none
module vcie_eoi_ctrl_bench;
  import vcie_pkg::*;
  typedef struct packed {logic w; logic [15:0] enc; logic [7:0] ctl; logic [2:0] exp;} vcie_row_t;
  // Control order: ns, el1, enable, tc, trap_deactivate, trap_group0_all, fiq, irq
  localparam logic [7:0] VIRT = 8'he3;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic issue = 1'b0;
  logic wr = 1'b0;
  logic [15:0] enc = '0;
  logic [31:0] wdata = '0;
  logic [7:0] ctl = 8'hff;
  logic [2:0] group0_binary_point_i = 3'h3;
  logic acc_valid_i, acc_write_i, el1_i, nonsecure_i, sysreg_enable_i, trap_common_regs_i;
  logic trap_deactivate_i, trap_group0_all_i, fiq_route_override_i, irq_route_override_i;
  logic [15:0] acc_enc_i;
  logic [31:0] acc_wdata_i, acc_rdata_o;
  logic acc_done_o, trap_el1_o, trap_el2_o, phys_access_o, prio_drop_o, deactivate_o;
  logic system_error_interrupt_o, split_eoi_select_o, shared_binary_point_o;
  logic [23:0] interrupt_identifier_o;
  logic [2:0] group1_binary_point_o, group1_preempt_point_o;
  int errors = 0;
  int samples_checked = 0;
  vcie_row_t rows[11] = '{'{1'b0, ENC_CTRL, 8'hc0, 3'h4}, '{1'b0, ENC_CTRL, 8'hf3, 3'h2},
    '{1'b0, ENC_CTRL, 8'he0, 3'h1}, '{1'b1, ENC_DEACT, 8'he9, 3'h2}, '{1'b1, ENC_DEACT, 8'hf2, 3'h2},
    '{1'b1, ENC_DEACT, 8'he4, 3'h1}, '{1'b1, ENC_EOI0, 8'hf5, 3'h2}, '{1'b1, ENC_EOI0, 8'hf9, 3'h1},
    '{1'b1, ENC_EOI0, 8'h3f, 3'h1}, '{1'b0, ENC_CTRL, 8'hdf, 3'h4}, '{1'b0, ENC_BPR1, 8'he2, 3'h1}};
  assign {nonsecure_i, el1_i, sysreg_enable_i, trap_common_regs_i, trap_deactivate_i, trap_group0_all_i,
    fiq_route_override_i, irq_route_override_i} = ctl;
  always #25 clk_sys_i = ~clk_sys_i;
  vcie_pe_model pe (.clk_sys_i(clk_sys_i), .issue_i(issue), .write_i(wr), .enc_i(enc), .wdata_i(wdata),
    .acc_valid_o(acc_valid_i), .acc_write_o(acc_write_i), .enc_o(acc_enc_i), .wdata_o(acc_wdata_i));
  vcie_eoi_ctrl uut (.*);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acc(input logic [7:0] c, input logic w, input logic [15:0] e, input logic [31:0] d);
    @(posedge clk_sys_i);
    ctl <= c;
    issue <= 1'b1;
    wr <= w;
    enc <= e;
    wdata <= d;
    @(posedge clk_sys_i);
    issue <= 1'b0;
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic stop_test;
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (600) @(posedge clk_sys_i);
    errors++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    #1;
    chk("bpr1 reset", 32'h3, {29'h0, group1_binary_point_o});
    foreach (rows[i]) begin
      acc(rows[i].ctl, rows[i].w, rows[i].enc, 32'h0);
      chk("route", {29'h0, rows[i].exp}, {29'h0, trap_el1_o, trap_el2_o, phys_access_o});
    end
    // Split and shared are only trusted after this write
    acc(VIRT, 1'b1, ENC_CTRL, 32'hffff_fffe);
    chk("split set", 32'h2, {30'h0, split_eoi_select_o, shared_binary_point_o});
    acc(VIRT, 1'b0, ENC_CTRL, 32'h0);
    chk("ctrl read", 32'h0000_0402, acc_rdata_o);
    chk("ctrl done", 32'h1, {31'h0, acc_done_o});
    acc(VIRT, 1'b1, ENC_EOI0, 32'hff12_3456);
    chk("eoi split", 32'h4, {29'h0, prio_drop_o, deactivate_o, system_error_interrupt_o});
    chk("eoi id", 32'h3456, {8'h0, interrupt_identifier_o});
    acc(VIRT, 1'b1, ENC_DEACT, 32'hff00_0077);
    chk("deact", 32'h2, {29'h0, prio_drop_o, deactivate_o, system_error_interrupt_o});
    chk("deact id", 32'h77, {8'h0, interrupt_identifier_o});
    acc(VIRT, 1'b1, ENC_CTRL, 32'h1);
    chk("split clear", 32'h1, {30'h0, split_eoi_select_o, shared_binary_point_o});
    acc(VIRT, 1'b1, ENC_EOI0, 32'h21);
    chk("eoi joint", 32'h6, {29'h0, prio_drop_o, deactivate_o, system_error_interrupt_o});
    acc(VIRT, 1'b1, ENC_DEACT, 32'h22);
    chk("deact off", 32'h1, {29'h0, prio_drop_o, deactivate_o, system_error_interrupt_o});
    chk("preempt sum", 32'h4, {29'h0, group1_preempt_point_o});
    @(posedge clk_sys_i);
    group0_binary_point_i <= 3'h7;
    acc(VIRT, 1'b1, ENC_BPR1, 32'h5);
    acc(VIRT, 1'b0, ENC_BPR1, 32'h0);
    chk("bpr1 shared", 32'h7, acc_rdata_o);
    chk("bpr1 kept", 32'h3, {29'h0, group1_binary_point_o});
    chk("preempt shared", 32'h7, {29'h0, group1_preempt_point_o});
    acc(VIRT, 1'b1, ENC_CTRL, 32'h0);
    acc(VIRT, 1'b1, ENC_BPR1, 32'h6);
    acc(VIRT, 1'b0, ENC_BPR1, 32'h0);
    chk("bpr1 own", 32'h6, acc_rdata_o);
    chk("preempt own", 32'h6, {29'h0, group1_preempt_point_o});
    acc(VIRT, 1'b1, ENC_BPR1, 32'h0);
    chk("bpr1 clamp", 32'h3, {29'h0, group1_binary_point_o});
    acc(VIRT, 1'b1, ENC_BPR1, 32'h5);
    chk("bpr1 write", 32'h5, {29'h0, group1_binary_point_o});
    @(posedge clk_sys_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    #1;
    chk("bpr1 rerun", 32'h3, {29'h0, group1_binary_point_o});
    stop_test();
  end
endmodule
bind vcie_eoi_ctrl vcie_eoi_chk #(.PRI_BITS(PRI_BITS), .ID_BITS(ID_BITS), .BPR0_MIN(BPR0_MIN)) chk_i (.*);
`default_nettype wire

// file: test/vcie_pe_model.sv
// Processor element model that issues system register accesses
`timescale 1ns/1ps
`default_nettype none
module vcie_pe_model (
  input wire logic clk_sys_i,
  input wire logic issue_i,
  input wire logic write_i,
  input wire logic [15:0] enc_i,
  input wire logic [31:0] wdata_i,
  output logic acc_valid_o = 1'b0,
  output logic acc_write_o = 1'b0,
  output logic [15:0] enc_o = '0,
  output logic [31:0] wdata_o = '0
);
  always @(posedge clk_sys_i) begin
    acc_valid_o <= issue_i;
    if (issue_i) begin
      acc_write_o <= write_i;
      enc_o <= enc_i;
      wdata_o <= wdata_i;
    end else begin
      // Idle data toggles so a stale value never looks valid
      wdata_o <= ~wdata_o;
    end
  end
endmodule
`default_nettype wire
